// File: rtl/mah_defs.svh
/*
 * Timing constants for the host-side converter controller.
 * Assumes a 20 MHz clk; all cycle counts derive from MAH_CLK_NS.
 */
`ifndef MAH_DEFS_SVH
`define MAH_DEFS_SVH

`define MAH_CLK_NS          50
`define MAH_T_RD_CONV_NS    655
`define MAH_T_RD_GAP_NS     50
`define MAH_T_PIPE_MIN_NS   200
`define MAH_T_PIPE_MAX_NS   400
`define MAH_T_WR_INT_NS     520
`define MAH_T_WR_READ_NS    350
`define MAH_T_READ_NS       100
`define MAH_T_WR_LOW_NS     100
// Least times and conversion waits round up, only the pipe maximum rounds down
`define MAH_CYC_UP(t)   (((t) + `MAH_CLK_NS - 1) / `MAH_CLK_NS)
`define MAH_CYC_DN(t)   ((t) / `MAH_CLK_NS)
`define MAH_RD_CONV_CYC `MAH_CYC_UP(`MAH_T_RD_CONV_NS)
`define MAH_RD_GAP_CYC  `MAH_CYC_UP(`MAH_T_RD_GAP_NS)
`define MAH_PIPE_CYC    `MAH_CYC_UP(`MAH_T_PIPE_MIN_NS)
`define MAH_PIPE_MAX    `MAH_CYC_DN(`MAH_T_PIPE_MAX_NS)
`define MAH_WR_INT_CYC  `MAH_CYC_UP(`MAH_T_WR_INT_NS)
`define MAH_WR_READ_CYC `MAH_CYC_UP(`MAH_T_WR_READ_NS)
`define MAH_READ_CYC    `MAH_CYC_UP(`MAH_T_READ_NS)
`define MAH_WR_LOW_CYC  `MAH_CYC_UP(`MAH_T_WR_LOW_NS)
`define MAH_PIPE_SKIP   2

`endif

// File: rtl/mah_pkg.sv
/*
 * Types for the host-side converter controller.
 * Assumes mah_defs.svh supplies the timing counts.
 */
package mah_pkg;

	typedef enum logic [7:0] {
		MAH_IDLE  = 8'h01,
		MAH_START = 8'h02,
		MAH_WAIT  = 8'h04,
		MAH_SLOW  = 8'h08,
		MAH_READ  = 8'h10,
		MAH_GAP   = 8'h20,
		MAH_WRLOW = 8'h40,
		MAH_PIPE  = 8'h80
	} mah_state_e;

	typedef logic [7:0] mah_data_t;
	typedef logic [5:0] mah_count_t;

	typedef struct packed {
		mah_state_e state;
		mah_count_t count;
		logic       csN;
		logic       rdN;
		logic       wrN;
		logic       chanSel;
		logic       chanReq;
		logic       modeHigh;
		logic       busy;
		logic       resultValid;
		mah_data_t  result;
		logic [1:0] pipeSkip;
		logic       intS1;
		logic       intS2;
		logic       rdyS1;
		logic       rdyS2;
		mah_data_t  dataS1;
		mah_data_t  dataS2;
		logic       strapDone;
	} mah_state_s;

endpackage

// File: rtl/mah_host.sv
/*
 * Host-side controller driving an 8-bit multi-step converter by its pins.
 * Assumes the converter's pins are wired to the ports named below and that
 * modeStrap equals the level tied to the converter's mode strap.
 */
`timescale 1ns/1ps
`include "mah_defs.svh"

module mah_host #(
	parameter int USE_PIPELINE = 0,
	parameter int NO_WAIT      = 0
) (
	input  wire logic            clk,
	input  wire logic            reset_n,
	input  wire logic            modeStrap,
	input  wire logic            startReq,
	input  wire logic            startChan,
	output logic                 busy,
	output logic                 resultValid,
	output mah_pkg::mah_data_t   result,
	output logic                 chipSelectN,
	output logic                 readStrobeN,
	output logic                 sampleStrobeN,
	output logic                 channelSelect,
	input  wire logic            conversionDoneN,
	input  wire logic            busReady,
	input  wire mah_pkg::mah_data_t resultBus
);
	import mah_pkg::*;

	mah_state_s q;
	mah_state_s d;
	logic [1:0] rstPipe;
	logic       rstSync;

	function automatic mah_count_t cyc(input int n);
		cyc = mah_count_t'(n);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Reset release, kept apart: it runs on the raw reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rstPipe <= 2'b00;
		end else begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rstSync = rstPipe[1];

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		d = q;
		d.intS1 = conversionDoneN;
		d.intS2 = q.intS1;
		d.rdyS1 = busReady;
		d.rdyS2 = q.rdyS1;
		d.dataS1 = resultBus;
		d.dataS2 = q.dataS1;
		d.resultValid = 1'b0;
		if (q.count != '0)
			d.count = q.count - 6'h01;
		if (!q.strapDone) begin
			d.modeHigh = modeStrap;
			d.strapDone = 1'b1;
		end
		case (q.state)
		MAH_IDLE: begin
			d.busy = 1'b0;
			if (startReq && q.strapDone) begin
				d.chanReq = startChan;
				d.chanSel = startChan;
				d.busy = 1'b1;
				d.csN = 1'b0;
				d.state = MAH_START;
			end
		end
		MAH_START: begin
			if (q.modeHigh) begin
				d.wrN = 1'b0;
				d.count = cyc(`MAH_WR_LOW_CYC);
				d.state = MAH_WRLOW;
			end else if (USE_PIPELINE != 0) begin
				d.rdN = 1'b0;
				d.count = cyc(`MAH_PIPE_CYC);
				d.state = MAH_PIPE;
			end else begin
				d.rdN = 1'b0;
				d.count = cyc(`MAH_RD_CONV_CYC);
				d.state = MAH_WAIT;
			end
		end
		MAH_WRLOW: begin
			if (q.count == '0) begin
				d.wrN = 1'b1;
				d.count = (NO_WAIT != 0) ?
					cyc(`MAH_WR_READ_CYC) :
					cyc(`MAH_WR_INT_CYC);
				d.state = MAH_SLOW;
			end
		end
		MAH_SLOW: begin
			// Early read is safe: done is forced low on the fall
			if (q.count == '0 || !q.intS2) begin
				d.rdN = 1'b0;
				d.count = cyc(`MAH_READ_CYC);
				d.state = MAH_READ;
			end
		end
		MAH_WAIT: begin
			// Done low and ready high mark the end of conversion
			if ((!q.intS2 && q.rdyS2) || q.count == '0) begin
				d.count = cyc(`MAH_READ_CYC);
				d.state = MAH_READ;
			end
		end
		MAH_PIPE: begin
			if (q.count == '0) begin
				d.result = q.dataS2;
				if (q.pipeSkip == 2'(`MAH_PIPE_SKIP))
					d.resultValid = 1'b1;
				else
					d.pipeSkip = q.pipeSkip + 2'h1;
				d.rdN = 1'b1;
				d.csN = 1'b1;
				d.count = cyc(`MAH_RD_GAP_CYC);
				d.state = MAH_GAP;
			end
		end
		MAH_READ: begin
			if (q.count == '0) begin
				d.result = q.dataS2;
				// First result after reset is discarded
				d.resultValid = q.pipeSkip != 2'h0;
				d.pipeSkip = 2'h1;
				d.rdN = 1'b1;
				d.csN = 1'b1;
				d.count = cyc(`MAH_RD_GAP_CYC);
				d.state = MAH_GAP;
			end
		end
		MAH_GAP: begin
			if (q.count == '0)
				d.state = MAH_IDLE;
		end
		default: d.state = MAH_IDLE;
		endcase
		d.busy = (d.state != MAH_IDLE);
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			q.state       <= MAH_IDLE;
			q.count       <= '0;
			q.csN         <= 1'b1;
			q.rdN         <= 1'b1;
			q.wrN         <= 1'b1;
			q.chanSel     <= 1'b0;
			q.chanReq     <= 1'b0;
			q.modeHigh    <= 1'b0;
			q.busy        <= 1'b0;
			q.resultValid <= 1'b0;
			q.result      <= 8'h00;
			q.pipeSkip    <= 2'h0;
			q.intS1       <= 1'b1;
			q.intS2       <= 1'b1;
			q.rdyS1       <= 1'b1;
			q.rdyS2       <= 1'b1;
			q.dataS1      <= 8'h00;
			q.dataS2      <= 8'h00;
			q.strapDone   <= 1'b0;
		end else begin
			q.state       <= d.state;
			q.count       <= d.count;
			q.csN         <= d.csN;
			q.rdN         <= d.rdN;
			q.wrN         <= d.wrN;
			q.chanSel     <= d.chanSel;
			q.chanReq     <= d.chanReq;
			q.modeHigh    <= d.modeHigh;
			q.busy        <= d.busy;
			q.resultValid <= d.resultValid;
			q.result      <= d.result;
			q.pipeSkip    <= d.pipeSkip;
			q.intS1       <= d.intS1;
			q.intS2       <= d.intS2;
			q.rdyS1       <= d.rdyS1;
			q.rdyS2       <= d.rdyS2;
			q.dataS1      <= d.dataS1;
			q.dataS2      <= d.dataS2;
			q.strapDone   <= d.strapDone;
		end
	end

	assign busy          = q.busy;
	assign resultValid   = q.resultValid;
	assign result        = q.result;
	assign chipSelectN   = q.csN;
	assign readStrobeN   = q.rdN;
	assign sampleStrobeN = q.wrN;
	assign channelSelect = q.chanSel;

endmodule

// File: bench/mah_host_chk.sv
/* Pin-level assertions for mah_host.
   Bound to mah_host from the bench top file. */
`timescale 1ns/1ps
module mah_host_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic startReq,
	input wire logic startChan,
	input wire logic busy,
	input wire logic resultValid,
	input wire logic chipSelectN,
	input wire logic readStrobeN,
	input wire logic sampleStrobeN,
	input wire logic channelSelect
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	chk_start_take: assert property (
		startReq && !busy |=> busy && !chipSelectN
		&& channelSelect == $past(startChan)) else $error("no start");
	chk_select_read: assert property (
		!readStrobeN |-> !chipSelectN) else $error("read unselected");
	chk_sample_width: assert property (
		$fell(sampleStrobeN) |-> !sampleStrobeN[*2] ##[1:2] sampleStrobeN)
		else $error("sample width");
	chk_read_gap: assert property (
		$rose(readStrobeN) |-> readStrobeN[*2]) else $error("read gap");
	chk_read_hold: assert property (
		$fell(readStrobeN) |-> !readStrobeN[*2]) else $error("read short");
	chk_valid_read: assert property (
		resultValid |-> busy && !$past(readStrobeN, 2))
		else $error("valid without read");
	chk_idle_quiet: assert property (
		!busy |-> chipSelectN && readStrobeN && sampleStrobeN)
		else $error("strobe while idle");
	chk_conv_bound: assert property (
		$fell(chipSelectN) |-> ##[1:40] $rose(chipSelectN))
		else $error("conversion hangs");
endmodule

// File: bench/mah_conv_model.sv
/* Behavioural converter seen at its pins.
   Assumes the bench supplies both input samples. */
`timescale 1ns/1ps
module mah_conv_model (
	input  wire logic       csN,
	input  wire logic       rdN,
	input  wire logic       wrN,
	input  wire logic       chan,
	input  wire logic       strap,
	input  wire logic [7:0] vin0,
	input  wire logic [7:0] vin1,
	output logic            doneN,
	output logic            ready,
	output logic [7:0]      bus
);
	logic [7:0] data;
	logic       chanL;
	int         t, lim, err;
	// Estimator picks a tap group; two flashes use seven comparators each
	function automatic logic [7:0] multistep(input int v, input int e);
		int         n, f, r, code, corr;
		logic [2:0] mid;
		n = 0;
		f = 0;
		r = 0;
		for (int k = 0; k < 6; k++)
			n += int'(v + e >= 48 + 32 * k);
		code = (n + 1) / 2;
		for (int k = 1; k < 8; k++)
			f += int'(v >= 32 * n + 8 * k);
		corr = (n % 2 == 1 && f < 4) ? code - 1 : code;
		mid = 3'(n % 2 == 1 ? f ^ 4 : f);
		for (int k = 1; k < 8; k++)
			r += int'(v >= 64 * corr + 8 * mid + k);
		return {2'(corr), mid, 3'(r)};
	endfunction
	initial begin
		doneN = 1'b1;
		ready = 1'b1;
		chanL = 1'b1;
	end
	// Released bus shows the inverse of the result
	assign bus = (!csN && !rdN && !doneN) ? data : ~data;
	always @(negedge csN) ready = 1'b0;
	always @(posedge rdN) doneN = 1'b1;
	always @(negedge rdN or negedge wrN) begin
		if (!csN && (strap ? !wrN : !rdN)) begin
			doneN = 1'b1;
			// Estimator error within what the overlap absorbs
			err = int'($urandom_range(32)) - 16;
			data = multistep(chanL ? vin1 : vin0, err);
			if (strap) @(posedge wrN);
			t = 0;
			// Converter may finish early, so done decides then
			lim = strap ? 400 + $urandom_range(120) :
				500 + $urandom_range(155);
			// In strap mode an early read ends the wait
			while (t < lim && !(strap && !rdN)) begin
				#5;
				t += 5;
			end
			doneN = 1'b0;
			ready = 1'b1;
			chanL = chan;
		end
	end
endmodule

// File: bench/mah_host_test.sv
/* Self-checking bench for mah_host with the converter model.
   Assumes mah_pkg and mah_defs.svh are compiled first. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module mah_host_test;
	import mah_pkg::*;
	logic      clk, reset_n, modeStrap, startReq, startChan, prevChan;
	logic      busy, resultValid, chipSelectN, readStrobeN, sampleStrobeN;
	logic      channelSelect, conversionDoneN, busReady;
	mah_data_t result, resultBus, expd, vin0, vin1;
	mah_data_t expQ[$];
	int        failures, cmp_count;
	mah_host i_mah_host (.clk(clk), .reset_n(reset_n), .modeStrap(modeStrap),
		.startReq(startReq), .startChan(startChan), .busy(busy),
		.resultValid(resultValid), .result(result),
		.chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
		.sampleStrobeN(sampleStrobeN), .channelSelect(channelSelect),
		.conversionDoneN(conversionDoneN), .busReady(busReady),
		.resultBus(resultBus));
	mah_conv_model i_mah_conv_model (.csN(chipSelectN), .rdN(readStrobeN),
		.wrN(sampleStrobeN), .chan(channelSelect), .strap(modeStrap),
		.vin0(vin0), .vin1(vin1), .doneN(conversionDoneN), .ready(busReady),
		.bus(resultBus));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(negedge clk) begin
		if (resultValid === 1'b1) begin
			expd = expQ.size() > 0 ? expQ.pop_front() : 'x;
			`CHK("result", expd, result)
		end
	end
	task end_of_test();
		if (failures == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task rst(input logic m);
		reset_n <= 1'b0;
		modeStrap <= m;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
	task conv(input logic keep);
		logic [7:0] v0, v1;
		logic       c;
		int         n;
		{c, v1, v0} = 17'($urandom);
		vin0 <= v0;
		vin1 <= v1;
		startChan <= c;
		startReq <= 1'b1;
		if (keep) expQ.push_back(prevChan ? v1 : v0);
		prevChan = c;
		@(posedge clk);
		startReq <= 1'b0;
		repeat (3) @(posedge clk);
		startReq <= 1'b1; // Ignored while busy
		@(posedge clk);
		startReq <= 1'b0;
		n = 0;
		while (busy !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n == 100) begin
			failures++;
			end_of_test();
		end
		@(posedge clk);
	endtask
	initial begin
		reset_n = 1'b0;
		modeStrap = 1'b0;
		startReq = 1'b0;
		startChan = 1'b0;
		vin0 = 8'h00;
		vin1 = 8'h00;
		void'($urandom(30));
		for (int m = 0; m < 2; m++) begin
			rst(m[0]);
			conv(1'b0);
			repeat (4) conv(1'b1);
		end
		`CHK("pending", 0, expQ.size())
		end_of_test();
	end
endmodule
bind mah_host mah_host_chk i_mah_host_chk (.clk(clk), .reset_n(reset_n),
	.startReq(startReq), .startChan(startChan), .busy(busy),
	.resultValid(resultValid), .chipSelectN(chipSelectN),
	.readStrobeN(readStrobeN), .sampleStrobeN(sampleStrobeN),
	.channelSelect(channelSelect));
